/* File: aefl_top.v */
// error flag and interrupt enable logic of the list-driven converter
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "aefl_consts.vh"
module aefl_top #(
	parameter ADDR_W = 5,
	parameter DATA_W = 8
) (
	input  wire              CLK_SYS,
	input  wire              NRST,
	input  wire              CKE,
	input  wire [ADDR_W-1:0] ADDR,
	input  wire [DATA_W-1:0] WDATA,
	input  wire              WR,
	input  wire              RD,
	output wire [DATA_W-1:0] RDATA,
	input  wire              MOD_EN,
	input  wire              SOFT_RST,
	input  wire              STOP_EXIT,
	input  wire              RESTART_MODE,
	input  wire              SINGLE_LIST,
	input  wire              ABORT_TIMING_SELECT,
	input  wire              LOAD_ALTERNATIVE_LIST_BIT,
	input  wire              SEQUENCE_ABORT_BIT,
	input  wire              EV_STORE_ACC_ERR,
	input  wire              EV_FETCH_OUT_RANGE,
	input  wire              EV_CMD_RESERVED,
	input  wire              EV_RES_RESERVED,
	input  wire              EV_NO_LIST_END,
	input  wire              EV_TRIG_BUS,
	input  wire              EV_TRIG_HW,
	input  wire              EV_RESTART,
	input  wire              EV_RESTART_OVR,
	input  wire              EV_ABORT_REQ,
	input  wire              EV_ABORT_DONE,
	input  wire              RESTART_LOADING,
	input  wire              SEQ_ACTIVE,
	input  wire              FIRST_SAMPLE,
	input  wire              LIST_END_DONE,
	input  wire              LIST_END_NEAR,
	input  wire              ABORT_DONE_FLAG,
	input  wire              OVERRUN_FLAG,
	output wire [DATA_W-1:0] ERROR_FLAGS,
	output wire              HALT,
	output wire              IRQ_ABORT_DONE,
	output wire              IRQ_OVERRUN
);

	// register bus and enable state
	reg  [DATA_W-1:0] ie_ff;
	reg  [DATA_W-1:0] nxt_ie;
	reg  [DATA_W-1:0] rdata_ff;
	reg  [DATA_W-1:0] nxt_rdata;

	// flow tracking state
	reg               first_rst_ff;
	reg               nxt_first_rst;
	reg               aborted_ff;
	reg               nxt_aborted;
	reg               restart_seen_ff;
	reg               nxt_restart_seen;
	reg               trig_run_ff;
	reg               nxt_trig_run;

	// outputs held in flip-flops
	reg               halt_ff;
	reg               nxt_halt;
	reg               irq_abort_ff;
	reg               irq_ovr_ff;

	// flag cell controls
	reg  [DATA_W-1:0] flag_set;
	reg  [DATA_W-1:0] flag_clr;
	wire [DATA_W-1:0] flags;
	wire              hold_clr;

	// condition terms
	wire              wr_ie;
	wire              wr_ef;
	wire              trig_any;
	wire              trig_mode;
	wire              trig_err;
	wire              rstar_err;
	wire              load_alternative_list_bit_err;
	wire              abort_near;

	// address decode used by both read and write paths
	function hit;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	assign wr_ie     = WR & hit(ADDR, `AEFL_OFS_IE);
	assign wr_ef     = WR & hit(ADDR, `AEFL_OFS_EF);
	assign trig_any  = EV_TRIG_BUS | EV_TRIG_HW;
	assign trig_mode = ~RESTART_MODE;
	assign hold_clr  = ~MOD_EN;

	// interrupt enable register, only the two defined bits are kept
	always @* begin
		nxt_ie = ie_ff;
		if (wr_ie)
			nxt_ie = WDATA & `AEFL_IE_MASK;
	end

	// read data stand only in the cycle after the read strobe
	always @* begin
		nxt_rdata = {DATA_W{1'b0}};
		if (RD) begin
			if (hit(ADDR, `AEFL_OFS_IE))
				nxt_rdata = ie_ff;
			else if (hit(ADDR, `AEFL_OFS_EF))
				nxt_rdata = flags;
		end
	end

	// trigger error: abort or unfinished restart in restart mode
	// bus trigger before first restart and colliding triggers in trigger mode
	// busy sequence or first sample in progress in either mode
	assign trig_err =
		(RESTART_MODE & trig_any & aborted_ff) |
		(RESTART_MODE & trig_any & RESTART_LOADING) |
		(trig_mode & EV_TRIG_BUS & ~restart_seen_ff) |
		(trig_any & SEQ_ACTIVE) |
		(trig_any & FIRST_SAMPLE) |
		(trig_mode & EV_TRIG_HW & EV_TRIG_BUS);

	// list end is near only when the abort timing select asks for it
	assign abort_near = ABORT_TIMING_SELECT & LIST_END_NEAR;

	// restart request error while a triggered sequence is still running
	assign rstar_err = EV_RESTART & trig_run_ff &
		~LIST_END_DONE & ~abort_near &
		~SEQUENCE_ABORT_BIT & ~EV_ABORT_REQ &
		~EV_RESTART_OVR;

	// load-ok error only in restart mode, with the listed exemptions
	assign load_alternative_list_bit_err = RESTART_MODE & EV_RESTART &
		~LOAD_ALTERNATIVE_LIST_BIT &
		~SEQUENCE_ABORT_BIT & ~EV_ABORT_REQ &
		~first_rst_ff & ~SINGLE_LIST;

	// set and clear vectors for the flag cells
	always @* begin
		flag_set = {DATA_W{1'b0}};
		flag_set[`AEFL_EF_IA]    = EV_STORE_ACC_ERR |
			EV_FETCH_OUT_RANGE;
		flag_set[`AEFL_EF_CMD]   = EV_CMD_RESERVED |
			EV_RES_RESERVED;
		flag_set[`AEFL_EF_EOL]   = EV_NO_LIST_END;
		flag_set[`AEFL_EF_TRIG]  = trig_err;
		flag_set[`AEFL_EF_RSTAR] = rstar_err;
		flag_set[`AEFL_EF_LOAD_ALTERNATIVE_LIST_BIT]  = load_alternative_list_bit_err;
		// soft reset clears every flag, a write of one only the two
		flag_clr = {DATA_W{SOFT_RST}};
		if (wr_ef)
			flag_clr = flag_clr | (WDATA & `AEFL_EF_W1C);
	end

	// one sticky cell per flag bit, reserved bits never set
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_flag
			aefl_flag u_flag (
				.clk      (CLK_SYS),
				.nrst     (NRST),
				.cke      (CKE),
				.hold_clr (hold_clr),
				.set      (flag_set[gi]),
				.clr      (flag_clr[gi]),
				.q        (flags[gi])
			);
		end
	endgenerate

	// halt follows the severe flags as they will stand next cycle
	always @* begin
		nxt_halt = 1'b0;
		if (MOD_EN) begin
			if (|(flag_set & `AEFL_EF_SEVERE))
				nxt_halt = 1'b1;
			else if (!SOFT_RST)
				nxt_halt = |(flags & `AEFL_EF_SEVERE);
		end
	end

	// first restart after enable, stop exit or soft reset is exempt
	always @* begin
		nxt_first_rst = first_rst_ff;
		if (!MOD_EN || SOFT_RST || STOP_EXIT)
			nxt_first_rst = 1'b1;
		else if (EV_RESTART)
			nxt_first_rst = 1'b0;
	end

	// in restart mode a completed abort waits for a restart before a trigger is legal
	always @* begin
		nxt_aborted = aborted_ff;
		if (!MOD_EN || SOFT_RST)
			nxt_aborted = 1'b0;
		else if (EV_RESTART)
			nxt_aborted = 1'b0;
		else if (EV_ABORT_DONE)
			nxt_aborted = 1'b1;
	end

	// trigger mode needs one restart before any bus trigger
	always @* begin
		nxt_restart_seen = restart_seen_ff;
		if (!MOD_EN || SOFT_RST)
			nxt_restart_seen = 1'b0;
		else if (EV_RESTART)
			nxt_restart_seen = 1'b1;
	end

	// a triggered sequence runs until its list end or an abort
	always @* begin
		nxt_trig_run = trig_run_ff;
		if (!MOD_EN || SOFT_RST)
			nxt_trig_run = 1'b0;
		else if (LIST_END_DONE || EV_ABORT_REQ || SEQUENCE_ABORT_BIT)
			nxt_trig_run = 1'b0;
		else if (trig_any)
			nxt_trig_run = 1'b1;
	end

	// state registers, frozen while clock enable is low
	always @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ie_ff           <= `AEFL_IE_RST;
			rdata_ff        <= {DATA_W{1'b0}};
			first_rst_ff    <= 1'b1;
			aborted_ff      <= 1'b0;
			restart_seen_ff <= 1'b0;
			trig_run_ff     <= 1'b0;
			halt_ff         <= 1'b0;
			irq_abort_ff    <= 1'b0;
			irq_ovr_ff      <= 1'b0;
		end else if (CKE) begin
			ie_ff           <= nxt_ie;
			rdata_ff        <= nxt_rdata;
			first_rst_ff    <= nxt_first_rst;
			aborted_ff      <= nxt_aborted;
			restart_seen_ff <= nxt_restart_seen;
			trig_run_ff     <= nxt_trig_run;
			halt_ff         <= nxt_halt;
			// request follows flag and enable bit
			irq_abort_ff    <= ABORT_DONE_FLAG &
				nxt_ie[`AEFL_IE_ABORT];
			irq_ovr_ff      <= OVERRUN_FLAG &
				nxt_ie[`AEFL_IE_OVR];
		end
	end

	// outputs
	assign RDATA          = rdata_ff;
	assign ERROR_FLAGS    = flags;
	assign HALT           = halt_ff;
	assign IRQ_ABORT_DONE = irq_abort_ff;
	assign IRQ_OVERRUN    = irq_ovr_ff;

endmodule

/* File: aefl_consts.vh */
// register offsets, field positions and reset values of the error flag block
// Notes on behaviour
// - interrupt enable register at 0x07 holds abort-done enable bit.
// - same register holds the conversion flag overrun enable bit.
// - any set severe error flag stops all further conversion activity.
// - only a soft reset or module enable low resumes operation and clears severe flags.
// - restart and load-ok errors do not halt; write one or soft reset clears.
// - all error flags forced clear while module enable is low.
// - writing zero leaves a flag; writing one never sets a flag.
// - severe flags ignore writes; only restart and load-ok flags clear on one.
// - bit 7 set on result store access error or bad command fetch.
// - bit 6 set on reserved command bits or reserved resolution.
// - bit 5 set when executed list lacks an end-of-list command.
// - restart mode: trigger after abort without finished restart sets bit 3.
// - trigger mode: bus trigger before the first restart sets bit 3.
// - trigger during an unfinished sequence sets bit 3.
// - trigger while first command starts sampling sets bit 3.
// - trigger mode: hardware trigger coinciding with bus trigger sets bit 3.
// - restart after trigger before list end or abort sets bit 2.
// - restart overrun situations leave bit 2 clear.
// - restart mode: restart without load-alternative bit sets bit 1.
// - load-ok error suppressed on abort, first restart, single buffering.
`ifndef AEFL_CONSTS_VH
`define AEFL_CONSTS_VH

// register offsets
`define AEFL_OFS_IE      5'h07
`define AEFL_OFS_EF      5'h08

// interrupt enable fields
`define AEFL_IE_ABORT    7
`define AEFL_IE_OVR      6
`define AEFL_IE_MASK     8'hC0
`define AEFL_IE_RST      8'h00

// error flag fields
`define AEFL_EF_IA       7
`define AEFL_EF_CMD      6
`define AEFL_EF_EOL      5
`define AEFL_EF_TRIG     3
`define AEFL_EF_RSTAR    2
`define AEFL_EF_LOAD_ALTERNATIVE_LIST_BIT     1
`define AEFL_EF_RST      8'h00
`define AEFL_EF_SEVERE   8'hE8
`define AEFL_EF_W1C      8'h06

`endif

/* File: aefl_flag.v */
// one sticky flag bit with hold-clear, set and clear inputs
`timescale 1ns/1ps
module aefl_flag (
	input  wire clk,
	input  wire nrst,
	input  wire cke,
	input  wire hold_clr,
	input  wire set,
	input  wire clr,
	output wire q
);

	reg flag_ff;
	reg nxt_flag;

	// hold-clear wins, then a set beats any clear in the same cycle
	always @* begin
		nxt_flag = flag_ff;
		if (hold_clr)
			nxt_flag = 1'b0;
		else if (set)
			nxt_flag = 1'b1;
		else if (clr)
			nxt_flag = 1'b0;
	end

	// flag storage, frozen while clock enable is low
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			flag_ff <= 1'b0;
		else if (cke)
			flag_ff <= nxt_flag;
	end

	assign q = flag_ff;

endmodule

/* File: aefl_checker.sv */
// assertion checker bound to the error flag block top
`timescale 1ns/1ps
`include "aefl_consts.vh"
module aefl_checker #(
	parameter ADDR_W = 5,
	parameter DATA_W = 8
) (
	input wire              CLK_SYS,
	input wire              NRST,
	input wire              CKE,
	input wire [ADDR_W-1:0] ADDR,
	input wire [DATA_W-1:0] WDATA,
	input wire              WR,
	input wire              MOD_EN,
	input wire              SOFT_RST,
	input wire              EV_STORE_ACC_ERR,
	input wire              EV_CMD_RESERVED,
	input wire              EV_RES_RESERVED,
	input wire              EV_RESTART,
	input wire              ABORT_DONE_FLAG,
	input wire              OVERRUN_FLAG,
	input wire [DATA_W-1:0] ERROR_FLAGS,
	input wire              HALT,
	input wire              IRQ_ABORT_DONE,
	input wire              IRQ_OVERRUN
);
	// frozen clock or reset aborts every check
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST || !CKE);
	wire wr_ef = WR && ADDR == `AEFL_OFS_EF;
	wire cmd_ev = EV_CMD_RESERVED || EV_RES_RESERVED;
	a_halt_on_severe: assert property (
		HALT == |(ERROR_FLAGS & `AEFL_EF_SEVERE)) else $error("halt mismatch");
	a_access_sets: assert property (
		EV_STORE_ACC_ERR && MOD_EN |=> ERROR_FLAGS[7]) else $error("bit7 unset");
	a_command_sets: assert property (
		cmd_ev && MOD_EN |=> ERROR_FLAGS[6]) else $error("bit6 unset");
	a_disable_clears: assert property (
		!MOD_EN |=> ERROR_FLAGS == 8'h00) else $error("flags kept");
	a_severe_sticky: assert property (
		MOD_EN && !SOFT_RST |=> (ERROR_FLAGS & $past(ERROR_FLAGS) & 8'hE8)
		== ($past(ERROR_FLAGS) & 8'hE8)) else $error("severe flag lost");
	a_soft_clears: assert property (
		SOFT_RST && MOD_EN && !cmd_ev |=> !ERROR_FLAGS[6]) else $error("bit6 kept");
	a_w1c_clears: assert property (
		wr_ef && WDATA[1] && ERROR_FLAGS[1] && MOD_EN && !EV_RESTART
		|=> !ERROR_FLAGS[1]) else $error("bit1 kept");
	a_write_no_set: assert property (
		wr_ef && !ERROR_FLAGS[2] && !EV_RESTART |=> !ERROR_FLAGS[2])
		else $error("bit2 set by write");
	a_irq_abort_off: assert property (
		!ABORT_DONE_FLAG |=> !IRQ_ABORT_DONE) else $error("abort irq stuck");
	a_irq_ovr_cause: assert property (
		$rose(IRQ_OVERRUN) |-> $past(OVERRUN_FLAG)) else $error("overrun irq");
	// main scenarios reached
	cover property (HALT);
	cover property (IRQ_ABORT_DONE);
	cover property (ERROR_FLAGS[2]);
	cover property (ERROR_FLAGS[1]);
endmodule
bind aefl_top aefl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
	aefl_checker_inst (.*);

/* File: testbench.sv */
// self-checking testbench of the error flag block
`timescale 1ns/1ps
module testbench;
	logic        CLK_SYS, NRST, CKE, WR, RD, MOD_EN;
	logic        ABORT_DONE_FLAG, OVERRUN_FLAG;
	logic [4:0]  ADDR;
	logic [7:0]  WDATA;
	logic [12:0] ev;
	logic [9:0]  lv;
	wire  [7:0]  RDATA, ERROR_FLAGS;
	wire         HALT, IRQ_ABORT_DONE, IRQ_OVERRUN;
	int          fails, n_checks;
	// event pulses and engine levels fanned out to the ports
	wire EV_STORE_ACC_ERR = ev[0], EV_FETCH_OUT_RANGE = ev[1];
	wire EV_CMD_RESERVED = ev[2], EV_RES_RESERVED = ev[3];
	wire EV_NO_LIST_END = ev[4], EV_TRIG_BUS = ev[5], EV_RESTART = ev[6];
	wire EV_RESTART_OVR = ev[7], EV_TRIG_HW = ev[8], EV_ABORT_REQ = ev[9];
	wire EV_ABORT_DONE = ev[10], STOP_EXIT = ev[11], SOFT_RST = ev[12];
	wire SEQ_ACTIVE = lv[0], FIRST_SAMPLE = lv[1], LIST_END_DONE = lv[2];
	wire RESTART_LOADING = lv[3], SEQUENCE_ABORT_BIT = lv[4];
	wire LIST_END_NEAR = lv[5], ABORT_TIMING_SELECT = lv[6];
	wire RESTART_MODE = lv[7], SINGLE_LIST = lv[8];
	wire LOAD_ALTERNATIVE_LIST_BIT = lv[9];
	localparam logic [12:0] k_tb = 13'h0020, k_rs = 13'h0040,
		k_ro = 13'h0080, k_th = 13'h0100, k_ar = 13'h0200,
		k_ad = 13'h0400, k_sx = 13'h0800, k_sr = 13'h1000;
	localparam logic [9:0] l_rm = 10'h080;
	aefl_top aefl_top_inst (.*);
	always #50 CLK_SYS = ~CLK_SYS;
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task automatic pulse(input logic [12:0] m);
		@(posedge CLK_SYS) ev <= m;
		@(posedge CLK_SYS) ev <= '0;
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CLK_SYS) {ADDR, WDATA, WR} <= {a, d, 1'b1};
		@(posedge CLK_SYS) WR <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge CLK_SYS) {ADDR, RD} <= {a, 1'b1};
		@(posedge CLK_SYS) RD <= 1'b0;
		#1 chk("rdata", e, RDATA);
	endtask
	task automatic irq(input logic [1:0] e);
		cyc(2);
		chk("irq", {6'h0, e}, {6'h0, IRQ_ABORT_DONE, IRQ_OVERRUN});
	endtask
	// soft reset, set levels, up to four events, then judge flags
	task automatic flow(input logic [9:0] l, input logic [12:0] a, b, c, d,
		input logic [7:0] e);
		pulse(k_sr);
		@(posedge CLK_SYS) lv <= l;
		pulse(a);
		pulse(b);
		pulse(c);
		pulse(d);
		chk("flags", e, ERROR_FLAGS);
		chk("halt", {7'h0, |(e & 8'hE8)}, {7'h0, HALT});
		@(posedge CLK_SYS) lv <= '0;
	endtask
	task automatic s_regs();
		rd(5'h07, 8'h00);
		wr(5'h07, 8'hFF);
		rd(5'h07, 8'hC0);
		wr(5'h10, 8'h55);
		rd(5'h10, 8'h00);
		rd(5'h07, 8'hC0);
		wr(5'h07, 8'h00);
	endtask
	task automatic s_irq();
		@(posedge CLK_SYS) {ABORT_DONE_FLAG, OVERRUN_FLAG} <= 2'b11;
		wr(5'h07, 8'h80);
		irq(2'b10);
		wr(5'h07, 8'h40);
		irq(2'b01);
		wr(5'h07, 8'hC0);
		@(posedge CLK_SYS) OVERRUN_FLAG <= 1'b0;
		irq(2'b10);
		@(posedge CLK_SYS) ABORT_DONE_FLAG <= 1'b0;
		irq(2'b00);
		wr(5'h07, 8'h00);
	endtask
	task automatic s_severe();
		logic [12:0] m [5] = '{13'h1, 13'h2, 13'h4, 13'h8, 13'h10};
		logic [7:0] x [5] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20};
		for (int i = 0; i < 5; i++) flow(0, m[i], 0, 0, 0, x[i]);
	endtask
	task automatic s_trigger();
		flow(10'h000, k_tb, 0, 0, 0, 8'h08);
		flow(10'h000, k_rs, k_th | k_tb, 0, 0, 8'h08);
		flow(10'h001, k_rs, k_tb, 0, 0, 8'h08);
		flow(10'h002, k_rs, k_tb, 0, 0, 8'h08);
		flow(l_rm, k_rs, k_ad, k_tb, 0, 8'h08);
		flow(10'h088, k_rs, k_tb, 0, 0, 8'h08);
	endtask
	task automatic s_restart();
		flow(10'h000, k_rs, k_tb, k_rs, 0, 8'h04);
		flow(10'h000, k_rs, k_tb, k_rs | k_ro, 0, 8'h00);
		flow(10'h000, k_rs, k_tb, k_ar, k_rs, 8'h00);
		flow(10'h004, k_rs, k_tb, k_rs, 0, 8'h00);
		flow(10'h060, k_rs, k_tb, k_rs, 0, 8'h00);
	endtask
	task automatic s_loadok();
		flow(l_rm, k_rs, k_rs, 0, 0, 8'h02);
		flow(10'h280, k_rs, k_rs, 0, 0, 8'h00);
		flow(10'h180, k_rs, k_rs, 0, 0, 8'h00);
		flow(10'h090, k_rs, k_rs, 0, 0, 8'h00);
		flow(l_rm, k_rs, k_sx, k_rs, 0, 8'h00);
		flow(l_rm, k_rs, k_rs | k_ar, 0, 0, 8'h00);
	endtask
	task automatic s_w1c();
		flow(l_rm, k_rs, k_rs, 13'h4, 0, 8'h42);
		wr(5'h08, 8'h00);
		rd(5'h08, 8'h42);
		wr(5'h08, 8'hFF);
		rd(5'h08, 8'h40);
		pulse(k_sr);
		rd(5'h08, 8'h00);
	endtask
	task automatic s_disable();
		pulse(13'h4);
		@(posedge CLK_SYS) MOD_EN <= 1'b0;
		cyc(2);
		chk("flags", 8'h00, ERROR_FLAGS);
		pulse(13'h4);
		wr(5'h08, 8'hFF);
		chk("flags", 8'h00, ERROR_FLAGS);
		@(posedge CLK_SYS) MOD_EN <= 1'b1;
		rd(5'h08, 8'h00);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// reset, then every scenario in turn
	initial begin
		{CLK_SYS, NRST, WR, RD, ABORT_DONE_FLAG, OVERRUN_FLAG} = '0;
		{ADDR, WDATA, ev, lv, fails, n_checks} = '0;
		{CKE, MOD_EN} = 2'b11;
		repeat (16) @(posedge CLK_SYS);
		NRST <= 1'b1;
		s_regs();
		s_irq();
		s_severe();
		s_trigger();
		s_restart();
		s_loadok();
		s_w1c();
		s_disable();
		print_verdict();
	end
endmodule
